// *** design/ddr_burst2_sram_port.sv ***
// Function
// - a read starts when read_sel_n is low at a true input clock rise.
// - read address is captured at the true input clock rise carrying the read.
// - write address is captured at the next complementary input clock rise.
// - one shared address bus: read address true half, write address complement half.
// - every read returns two words, every write accepts two words.
// - second burst address comes from a fixed two-bit sequential counter.
// - first read word follows the next complementary input rise, on output clock.
// - second read word follows on the next true output clock rise.
// - back-to-back reads stream data on every output clock edge without gaps.
// - with both output clocks held high, read data is timed from input clocks.
// - a deselected read finishes its pending burst before entering deselect.
// - after the final burst, read outputs go to high impedance automatically.
// - command, address, data and mask inputs are sampled on true or complementary input clock rises.
// - write data words are accepted on both input clock rises.
// - read and write ports are independent and may operate in one cycle.
// - an echo clock pair aligned to read data is driven out.
// - active-low lane masks gate write lanes of the organisation.
// - on x8, two active-low nibble masks gate half-width groups.
// - the delay-locked loop is disabled while dll_bypass_n is low.
// - write starts at true rise with first word; second word at complement rise.
// - each nine-bit lane has its own mask, lowest lane first.
// - the echo clock pair toggles continuously during normal operation.
`timescale 1ns/10ps
module ddr_burst2_sram_port #(
  parameter int ADDR_W = burst_sram_pkg::ADDR_W_DEF, // word address bits
  parameter int DATA_W = burst_sram_pkg::DATA_W_DEF, // organisation width
  parameter int LANES  = 1,                          // masked lanes
  parameter int DEPTH_LOG = 8                        // bits of modelled storage
) (
  input  wire logic              clk,              // system clock
  input  wire logic              nrst,             // async reset, active low
  input  wire logic              ce,               // clock enable
  input  wire logic              in_strobe_true,   // input clock, true
  input  wire logic              in_strobe_comp,   // input clock, complement
  input  wire logic              out_strobe_true,  // output clock, true
  input  wire logic              out_strobe_comp,  // output clock, complement
  input  wire logic              read_sel_n,       // read select, active low
  input  wire logic              store_sel_n,      // write select, active low
  input  wire logic [ADDR_W-1:0] addr_in,          // shared address bus
  input  wire logic [DATA_W-1:0] write_bus_in,     // write data
  input  wire logic [LANES-1:0]  lane_mask_n,      // lane masks, active low
  input  wire logic [1:0]        nibble_mask_n,    // x8 nibble masks, active low
  input  wire logic              x8_mode,          // x8 organisation select
  input  wire logic              dll_bypass_n,     // dll disable, active low
  output logic      [DATA_W-1:0] read_bus_out,     // read data
  output logic                   read_bus_oe,      // read drivers on
  output logic                   echo_timing_pair, // echo clock, true
  output logic                   echo_timing_pair_n, // echo clock, complement
  output logic                   dll_on            // dll running
);

  // lane width; x9 has one lane covering the whole word
  localparam int LW = DATA_W / LANES;

  // latency: a pin edge reaches the edge detectors two clk cycles later,
  // so each input half period must last at least three clk cycles
  // synchronisers: first stage read only by the second
  logic [5:0]        s1_reg;
  logic [5:0]        s2_reg;
  logic [5:0]        prev_reg;
  logic [ADDR_W-1:0] a1_reg;
  logic [ADDR_W-1:0] a2_reg;
  logic [DATA_W-1:0] d1_reg;
  logic [DATA_W-1:0] d2_reg;
  logic [LANES-1:0]  m1_reg;
  logic [LANES-1:0]  m2_reg;
  logic [1:0]        n1_reg;
  logic [1:0]        n2_reg;
  logic              r1_reg;
  logic              r2_reg;
  logic              w1_reg;
  logic              w2_reg;
  logic              x1_reg;
  logic              x2_reg;

  // every pin crosses two stages; buses ride with the strobes so that
  // an edge and the data it carries leave the second stage together
  // all state stays at its last value while ce is low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      prev_reg <= '0;
      a1_reg   <= '0;
      a2_reg   <= '0;
      d1_reg   <= '0;
      d2_reg   <= '0;
      m1_reg   <= '1;
      m2_reg   <= '1;
      n1_reg   <= 2'h3;
      n2_reg   <= 2'h3;
      r1_reg   <= 1'b1;
      r2_reg   <= 1'b1;
      w1_reg   <= 1'b1;
      w2_reg   <= 1'b1;
      x1_reg   <= 1'b0;
      x2_reg   <= 1'b0;
    end else if (ce) begin
      s1_reg   <= {dll_bypass_n, 1'b0, out_strobe_comp, out_strobe_true,
                   in_strobe_comp, in_strobe_true};
      s2_reg   <= s1_reg;
      prev_reg <= s2_reg;
      a1_reg   <= addr_in;
      a2_reg   <= a1_reg;
      d1_reg   <= write_bus_in;
      d2_reg   <= d1_reg;
      m1_reg   <= lane_mask_n;
      m2_reg   <= m1_reg;
      n1_reg   <= nibble_mask_n;
      n2_reg   <= n1_reg;
      r1_reg   <= read_sel_n;
      r2_reg   <= r1_reg;
      w1_reg   <= store_sel_n;
      w2_reg   <= w1_reg;
      x1_reg   <= x8_mode;
      x2_reg   <= x1_reg;
    end
  end

  // edge detection on the synchronised clocks; a pin already high when
  // reset lifts gives a rise, which starts a read or write if that select pin is already low
  wire k_rise  = s2_reg[0] & ~prev_reg[0];
  wire kb_rise = s2_reg[1] & ~prev_reg[1];
  wire c_rise  = s2_reg[2] & ~prev_reg[2];
  wire cb_rise = s2_reg[3] & ~prev_reg[3];
  // both output clocks high means single-clock timing; no flight-time
  // compensation is possible in that mode
  wire single_clk = s2_reg[2] & s2_reg[3];
  wire q_true_ev  = single_clk ? k_rise  : c_rise;
  wire q_comp_ev  = single_clk ? kb_rise : cb_rise;

  // storage array, low address bits only
  // no reset for the array: contents are undefined until written
  logic [DATA_W-1:0] mem [0:(1<<DEPTH_LOG)-1];

  // burst partner address, used by both ports so the order stays identical
  function automatic logic [DEPTH_LOG-1:0] burst_addr(input logic [ADDR_W-1:0] base,
                                                      input logic second);
    logic [1:0] low;
    low = base[1:0] + (second ? 2'(burst_sram_pkg::BURST_INC) : 2'h0);
    burst_addr = DEPTH_LOG'({base[ADDR_W-1:2], low});
  endfunction : burst_addr

  // merge new word over old under masks
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w,
                                              input logic [DATA_W-1:0] new_w,
                                              input logic [LANES-1:0] lm,
                                              input logic [1:0] nm,
                                              input logic x8);
    logic [DATA_W-1:0] r;
    r = old_w;
    for (int i = 0; i < DATA_W; i++) begin
      if (x8) begin
        if (!nm[(i / burst_sram_pkg::NIB_W) & 1]) r[i] = new_w[i];
      end else if (!lm[i / LW]) begin
        r[i] = new_w[i];
      end
    end
    merge = r;
  endfunction : merge

  // write port state; a select seen at a true rise arms the write and the
  // matching comp rise supplies the address and word1. a new write cannot
  // re-arm before that comp rise because true and comp rises alternate
  logic              wr_pend_reg;
  logic [DATA_W-1:0] wd0_reg;
  logic [LANES-1:0]  wm0_reg;
  logic [1:0]        wn0_reg;
  wire wr_start = k_rise & ~w2_reg;
  wire wr_fin   = kb_rise & wr_pend_reg;
  wire [DEPTH_LOG-1:0] wa0 = burst_addr(a2_reg, 1'b0);
  wire [DEPTH_LOG-1:0] wa1 = burst_addr(a2_reg, 1'b1);

  // word0 is parked until the write address shows up half a cycle later
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_reg <= 1'b0;
      wd0_reg     <= '0;
      wm0_reg     <= '1;
      wn0_reg     <= 2'h3;
    end else if (ce) begin
      if (wr_start) begin
        wr_pend_reg <= 1'b1;
        wd0_reg     <= d2_reg;
        wm0_reg     <= m2_reg;
        wn0_reg     <= n2_reg;
      end else if (wr_fin) begin
        wr_pend_reg <= 1'b0;
      end
    end
  end

  // memory writes: two words per command, both at complement rise
  always_ff @(posedge clk) begin
    if (ce && wr_fin) begin
      mem[wa0] <= merge(mem[wa0], wd0_reg, wm0_reg, wn0_reg, x2_reg);
      mem[wa1] <= merge(mem[wa1], d2_reg, m2_reg, n2_reg, x2_reg);
    end
  end

  // read port, independent of the write port: one captured read waits for
  // its comp rise, one burst waits for its second word. reads arrive one
  // per true rise and leave within one input period, so two slots suffice
  // limitation: a read and a write to the same words in one input period
  // return new data in normal mode; in single-clock mode word0 is old and word1 new
  // RD_SECOND is not used by this slot; the owed second word has its own flag
  burst_sram_pkg::rd_state_e rd_reg;   // captured read: idle, waiting, armed
  logic [ADDR_W-1:0] ra_reg;           // captured read address
  logic              bs_reg;           // second word still owed
  logic [ADDR_W-1:0] ba_reg;           // address of the burst in flight

  // read decode
  wire rd_req   = k_rise & ~r2_reg;
  wire rd_armed = (rd_reg == burst_sram_pkg::RD_FIRST) |
                  ((rd_reg == burst_sram_pkg::RD_WAIT) & kb_rise);
  wire rd_issue = rd_armed & q_comp_ev;
  wire rd_tail  = bs_reg & q_true_ev;
  wire rd_float = q_comp_ev & ~rd_issue & ~bs_reg;
  wire [DEPTH_LOG-1:0] rd_a0 = burst_addr(ra_reg, 1'b0);
  wire [DEPTH_LOG-1:0] rd_a1 = burst_addr(ba_reg, 1'b1);

  // captured-read slot; it is always free again before the next true rise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_reg <= burst_sram_pkg::RD_IDLE;
      ra_reg <= '0;
    end else if (ce) begin
      case (rd_reg)
        burst_sram_pkg::RD_IDLE: begin
          if (rd_req) begin
            ra_reg <= a2_reg;
            rd_reg <= burst_sram_pkg::RD_WAIT;
          end
        end
        burst_sram_pkg::RD_WAIT: begin
          if (rd_issue) begin
            rd_reg <= burst_sram_pkg::RD_IDLE;
          end else if (kb_rise) begin
            rd_reg <= burst_sram_pkg::RD_FIRST;
          end
        end
        burst_sram_pkg::RD_FIRST: begin
          if (rd_issue) begin
            rd_reg <= burst_sram_pkg::RD_IDLE;
          end
        end
        default: begin
          rd_reg <= burst_sram_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // output side: word0 at the comp event, word1 at the next true event;
  // drivers stay on across back-to-back bursts and drop at the first
  // comp event with nothing owed, so the pins never float mid stream
  // word1 never meets an issue: true and comp events alternate
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bs_reg       <= 1'b0;
      ba_reg       <= '0;
      read_bus_out <= '0;
      read_bus_oe  <= 1'b0;
    end else if (ce) begin
      if (rd_issue) begin
        read_bus_out <= mem[rd_a0];
        read_bus_oe  <= 1'b1;
        bs_reg       <= 1'b1;
        ba_reg       <= ra_reg;
      end else if (rd_tail) begin
        read_bus_out <= mem[rd_a1];
        bs_reg       <= 1'b0;
      end else if (rd_float) begin
        read_bus_oe  <= 1'b0;
      end
    end
  end

  // echo clocks follow the output timing events and run free, read or not
  // dll_on only mirrors the bypass pin; no lock delay is modelled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      echo_timing_pair   <= 1'b0;
      echo_timing_pair_n <= 1'b1;
      dll_on             <= 1'b0;
    end else if (ce) begin
      dll_on <= s2_reg[5];
      if (q_true_ev) begin
        echo_timing_pair <= 1'b1;
        echo_timing_pair_n <= 1'b0;
      end else if (q_comp_ev) begin
        echo_timing_pair <= 1'b0;
        echo_timing_pair_n <= 1'b1;
      end
    end
  end

endmodule : ddr_burst2_sram_port

// *** pkg/burst_sram_pkg.sv ***
package burst_sram_pkg;
  localparam int ADDR_W_DEF   = 20;   // word address width
  localparam int DATA_W_DEF   = 9;    // organisation width
  localparam int LANE_W_DEF   = 9;    // bits per masked lane
  localparam int NIB_W        = 4;    // half-width group on x8
  localparam int BURST_INC    = 1;    // second burst address step
  localparam logic [1:0] MODE_X9  = 2'h0;
  localparam logic [1:0] MODE_X8  = 2'h1;
  // read pipeline states
  typedef enum logic [1:0] {
    RD_IDLE  = 2'b00,
    RD_WAIT  = 2'b01,
    RD_FIRST = 2'b10,
    RD_SECOND = 2'b11
  } rd_state_e;
endpackage : burst_sram_pkg

// *** verif/ctrl_strobe_model.sv ***
`timescale 1ns/10ps
module ctrl_strobe_model (
  input  wire logic single_mode,     // hold output clocks high
  output logic      in_strobe_true,  // input clock, true
  output logic      in_strobe_comp,  // input clock, complement
  output logic      out_strobe_true, // output clock, true
  output logic      out_strobe_comp  // output clock, complement
);
  // free-running input pair, offset so edges never meet clk edges
  initial begin
    in_strobe_true = 1'b0;
    #13;
    forever #200 in_strobe_true = ~in_strobe_true;
  end
  assign in_strobe_comp = ~in_strobe_true;
  // output pair lags to mimic board flight time
  assign #100 out_strobe_true = single_mode | in_strobe_true;
  assign #100 out_strobe_comp = single_mode | in_strobe_comp;
endmodule : ctrl_strobe_model

// *** verif/sram_port_assertions.sv ***
`timescale 1ns/10ps
module sram_port_checker #(
  parameter int DATA_W = 9 // read word width
) (
  input wire logic              clk,                // system clock
  input wire logic              nrst,               // async reset, active low
  input wire logic              read_sel_n,         // read select
  input wire logic              dll_bypass_n,       // dll disable
  input wire logic [DATA_W-1:0] read_bus_out,       // read data
  input wire logic              read_bus_oe,        // read drivers on
  input wire logic              echo_timing_pair,   // echo clock
  input wire logic              echo_timing_pair_n, // echo complement
  input wire logic              dll_on              // dll running
);
  logic [7:0] rd_age_reg, echo_age_reg;
  // saturating ages, so a long idle never wraps back into range
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_age_reg   <= 8'hff;
      echo_age_reg <= 8'h00;
    end else begin
      rd_age_reg   <= !read_sel_n ? 8'h00 : rd_age_reg + 8'(rd_age_reg != 8'hff);
      echo_age_reg <= $changed(echo_timing_pair) ? 8'h00 : echo_age_reg + 8'(echo_age_reg != 8'hff);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_echo_pair: assert property (echo_timing_pair_n == !echo_timing_pair)
    else $error("echo pair not complementary");
  chk_echo_runs: assert property (echo_age_reg < 8'd12)
    else $error("echo clock stalled");
  chk_dll_on: assert property (dll_bypass_n [*6] |-> dll_on)
    else $error("dll not running");
  chk_dll_off: assert property (!dll_bypass_n [*6] |-> !dll_on)
    else $error("dll not stopped");
  chk_oe_cause: assert property ($rose(read_bus_oe) |-> rd_age_reg < 8'd40)
    else $error("drivers on without a read");
  chk_idle_float: assert property (rd_age_reg >= 8'd40 |-> !read_bus_oe)
    else $error("drivers left on when idle");
  chk_word_hold: assert property ($changed(read_bus_out) |=> $stable(read_bus_out) [*3])
    else $error("read word not held");
  chk_first_word: assert property ($rose(read_bus_oe) |-> $fell(echo_timing_pair))
    else $error("first word off the comp event");
  chk_float_edge: assert property ($fell(read_bus_oe) |-> $fell(echo_timing_pair))
    else $error("drivers off mid burst");
endmodule : sram_port_checker

bind ddr_burst2_sram_port sram_port_checker #(.DATA_W(DATA_W)) u_chk (.clk, .nrst, .read_sel_n,
  .dll_bypass_n, .read_bus_out, .read_bus_oe, .echo_timing_pair, .echo_timing_pair_n, .dll_on);

// *** verif/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0, nrst = 1'b0, single_mode = 1'b0, rd_n = 1'b1, wr_n = 1'b1, lm = 1'b1;
  logic dll_n = 1'b1, run = 1'b0, ist, isc, ost, osc, ts, cs, t_prev, c_prev, oe, echo, dll_on;
  logic [1:0] nm = 2'h3;
  logic [7:0] addr = 8'h00;
  logic [8:0] wd = 9'h000, rdata, mem [16], exp_q [$];
  logic [31:0] r;
  int mismatches = 0, comparisons = 0, seed = 32'hb93c;

  ctrl_strobe_model partner (.single_mode(single_mode), .in_strobe_true(ist),
    .in_strobe_comp(isc), .out_strobe_true(ost), .out_strobe_comp(osc));
  ddr_burst2_sram_port #(.ADDR_W(8)) dut (.clk(clk), .nrst(nrst), .ce(1'b1),
    .in_strobe_true(ist), .in_strobe_comp(isc), .out_strobe_true(ost),
    .out_strobe_comp(osc), .read_sel_n(rd_n), .store_sel_n(wr_n), .addr_in(addr),
    .write_bus_in(wd), .lane_mask_n(lm), .nibble_mask_n(nm), .x8_mode(1'b0),
    .dll_bypass_n(dll_n), .read_bus_out(rdata), .read_bus_oe(oe),
    .echo_timing_pair(echo), .echo_timing_pair_n(), .dll_on(dll_on));

  always #25 clk = ~clk;

  // burst partner: low two bits step and wrap
  function automatic logic [3:0] pair_addr(input logic [7:0] a);
    return {a[3:2], a[1:0] + 2'h1};
  endfunction : pair_addr

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test();
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  // change inputs mid half-period, clear of the synchroniser window
  task automatic edge_wait(input logic comp);
    if (comp) @(posedge isc);
    else @(posedge ist);
    repeat (2) @(posedge clk);
  endtask : edge_wait

  task automatic cmd(input logic rd, wr, input logic [7:0] ra, wa,
                     input logic [8:0] w0, w1, input logic m0, m1);
    edge_wait(1'b1);
    rd_n <= ~rd;
    wr_n <= ~wr;
    addr <= ra;
    wd <= w0;
    lm <= m0;
    nm <= 2'($random(seed));
    if (rd) exp_q.push_back(mem[ra[3:0]]);
    if (rd) exp_q.push_back(mem[pair_addr(ra)]);
    edge_wait(1'b0);
    addr <= wa;
    wd <= w1;
    lm <= m1;
    if (wr && !m0) mem[wa[3:0]] = w0;
    if (wr && !m1) mem[pair_addr(wa)] = w1;
  endtask : cmd

  // sample each word just before the port replaces it
  assign ts = single_mode ? ist : ost;
  assign cs = single_mode ? isc : osc;
  always @(posedge clk) begin
    t_prev <= ts;
    c_prev <= cs;
    if (run && ts && !t_prev) check({8'h0, echo}, 9'h0);
    if (run && ts && !t_prev && oe === 1'b1) check(rdata, exp_q.size() ? exp_q.pop_front() : ~rdata);
    if (run && cs && !c_prev) check({8'h0, echo}, 9'h1);
    if (run && cs && !c_prev && oe === 1'b1) check(rdata, exp_q.size() ? exp_q.pop_front() : ~rdata);
  end

  initial begin
    for (int pass = 0; pass < 2; pass++) begin
      run <= 1'b0;
      nrst <= 1'b0;
      single_mode <= 1'(pass);
      exp_q.delete();
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (16) @(posedge clk);
      run <= 1'b1;
      for (int i = 0; i < 16; i += 2) begin
        r = $random(seed);
        cmd(0, 1, 0, 8'(i), r[8:0], r[17:9], 0, 0);
      end
      // first reads run back to back; regions swap halfway
      for (int i = 0; i < 80; i++) begin
        r = $random(seed);
        dll_n <= !(i >= 20 && i < 30);
        if (i == 29) check({8'h0, dll_on}, 9'h0);
        cmd(i < 8 || r[0], r[1] && i % 40 > 2, {4'h0, 1'(i / 40), r[4:2]},
            {4'h0, 1'(i / 40 == 0), r[7:5]}, r[16:8], r[25:17], r[26] & r[27], r[28] & r[29]);
      end
      repeat (4) cmd(0, 0, 0, 0, 0, 0, 1, 1);
      check({8'h0, oe}, 9'h0);
      check(9'(exp_q.size()), 9'h0);
    end
    finish_test();
  end

  // hang guard, well past the expected run time
  initial begin
    #150000;
    mismatches++;
    finish_test();
  end
endmodule : tb_top
